// File: hw/irq_pkg.sv
// Shared constants and carrier types for the peripheral interrupt enable and priority block.
package irq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SRC_N  = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [11:0] OFF_EN_ONE   = 12'h000;
   localparam logic [11:0] OFF_EN_TWO   = 12'h004;
   localparam logic [11:0] OFF_PRIO_ONE = 12'h008;
   localparam logic [11:0] OFF_PRIO_TWO = 12'h00c;
   localparam logic [11:0] OFF_CTRL     = 12'h010;
   localparam logic [11:0] OFF_STATUS   = 12'h014;
   localparam logic [11:0] OFF_MASK     = 12'h018;
   localparam logic [11:0] OFF_FLAGS    = 12'h01c;

   ////////////////////////////////////////////////////////////////////////////////
   // Implemented positions and reset values of the 8-bit registers
   localparam logic [7:0] IMPL_ONE   = 8'h7f;
   localparam logic [7:0] IMPL_TWO   = 8'hfe;
   localparam logic [7:0] EN_RESET   = 8'h00;
   localparam logic [7:0] PRIO_RESET = 8'hff;

   // Source positions, first register
   localparam int unsigned BIT_CONVERTER_DONE   = 6;
   localparam int unsigned BIT_SERIAL_RX        = 5;
   localparam int unsigned BIT_SERIAL_TX        = 4;
   localparam int unsigned BIT_SYNC_PORT        = 3;
   localparam int unsigned BIT_CAPCOMP_ONE      = 2;
   localparam int unsigned BIT_TIMER_TWO_MATCH  = 1;
   localparam int unsigned BIT_TIMER_ONE_OVF    = 0;
   // Source positions, second register
   localparam int unsigned BIT_OSC_FAIL         = 7;
   localparam int unsigned BIT_COMPARATOR_ONE   = 6;
   localparam int unsigned BIT_COMPARATOR_TWO   = 5;
   localparam int unsigned BIT_NVM_WRITE_DONE   = 4;
   localparam int unsigned BIT_BUS_COLLISION    = 3;
   localparam int unsigned BIT_USB_EVENT        = 2;
   localparam int unsigned BIT_TIMER_THREE_OVF  = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int unsigned CTRL_PRIO_BIT  = 0;
   localparam int unsigned CTRL_GROUP_BIT = 1;
   localparam logic        CTRL_RESET     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic [7:0] two;
      logic [7:0] one;
   } src_bits_t;

   typedef struct packed {
      logic high;
      logic low;
   } irq_req_t;

   localparam src_bits_t IMPL_ALL = '{two: IMPL_TWO, one: IMPL_ONE};

endpackage : irq_pkg

// File: hw/peripheral_irq_enable_priority.sv
// Peripheral interrupt enable, priority routing and sticky event status behind an APB slave.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_enable_priority (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Peripheral flag lines
   input  wire irq_pkg::src_bits_t       flags,
   // Requests to the core sequencer
   output irq_pkg::irq_req_t             core_req,
   // Sticky event interrupt
   output logic                          irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   // Register contents are held as {two, one} pairs so the byte lanes line up with
   // the flag lines; reserved positions are kept at zero by every write path, and
   // the read path masks them again as a second line of defence.
   irq_pkg::src_bits_t enable;
   irq_pkg::src_bits_t prio;
   irq_pkg::src_bits_t status;
   irq_pkg::src_bits_t mask;
   irq_pkg::src_bits_t flag_q;
   // Control bits: scheme select, and the group gate used in single-level mode
   logic               priority_scheme_on;
   logic               periph_group_gate;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Decode is combinational from the request. Its results are only used while
   // psel is high, so a stale address between transfers does no harm, and the
   // full address is compared so an unaligned offset is refused, not aliased.
   logic        access;
   logic        done;
   logic        wr;
   logic        hit_en_one;
   logic        hit_en_two;
   logic        hit_prio_one;
   logic        hit_prio_two;
   logic        hit_ctrl;
   logic        hit_status;
   logic        hit_mask;
   logic        hit_flags;
   logic        hit_any;
   logic [31:0] next_rdata;

   // Access phase before the answer; one wait state keeps prdata a flop output
   assign access = psel & penable & ~pready;
   // Completing edge: the only edge where writes land
   assign done   = psel & penable & pready;
   assign wr     = done & pwrite & ~pslverr;

   // Word-aligned decode over the full address
   assign hit_en_one   = (paddr == irq_pkg::OFF_EN_ONE);
   assign hit_en_two   = (paddr == irq_pkg::OFF_EN_TWO);
   assign hit_prio_one = (paddr == irq_pkg::OFF_PRIO_ONE);
   assign hit_prio_two = (paddr == irq_pkg::OFF_PRIO_TWO);
   assign hit_ctrl     = (paddr == irq_pkg::OFF_CTRL);
   assign hit_status   = (paddr == irq_pkg::OFF_STATUS);
   assign hit_mask     = (paddr == irq_pkg::OFF_MASK);
   assign hit_flags    = (paddr == irq_pkg::OFF_FLAGS);
   assign hit_any      = hit_en_one | hit_en_two | hit_prio_one | hit_prio_two |
                         hit_ctrl | hit_status | hit_mask | hit_flags;

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer

   // Registers sit at word offsets; anything else decodes to the error response
   // Reserved positions are masked here too, so a stray value can never leak out
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (1'b1)
         hit_en_one:   next_rdata[7:0]  = enable.one & irq_pkg::IMPL_ONE;
         hit_en_two:   next_rdata[7:0]  = enable.two & irq_pkg::IMPL_TWO;
         hit_prio_one: next_rdata[7:0]  = prio.one & irq_pkg::IMPL_ONE;
         hit_prio_two: next_rdata[7:0]  = prio.two & irq_pkg::IMPL_TWO;
         hit_ctrl: begin
            next_rdata[irq_pkg::CTRL_PRIO_BIT]  = priority_scheme_on;
            next_rdata[irq_pkg::CTRL_GROUP_BIT] = periph_group_gate;
         end
         hit_status:   next_rdata[15:0] = status & irq_pkg::IMPL_ALL;
         hit_mask:     next_rdata[15:0] = mask & irq_pkg::IMPL_ALL;
         hit_flags:    next_rdata[15:0] = flags & irq_pkg::IMPL_ALL;
         default:      next_rdata = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB answer

   // Every transfer gets exactly one wait state. That costs a cycle per access but
   // lets read data and the error flag leave flops instead of the decode logic.
   // pready rises one cycle into the access phase and drops after the transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   // Write transfers return zero data; the bus never echoes the written word.
   // Unmapped addresses answer with pslverr, and a write to one changes nothing.
   // Data and error are loaded together with pready, so they are stable when sampled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= ~hit_any;
      end else if (!done) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Enable registers

   // Every source starts disabled; only implemented bits ever take a one
   // Only byte lane 0 carries these 8-bit registers; the other lanes are ignored.
   // A write to a reserved bit is dropped here rather than stored and hidden later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable.one <= irq_pkg::EN_RESET & irq_pkg::IMPL_ONE;
         enable.two <= irq_pkg::EN_RESET & irq_pkg::IMPL_TWO;
      end else if (wr && pstrb[0]) begin
         if (hit_en_one) begin
            enable.one <= pwdata[7:0] & irq_pkg::IMPL_ONE;
         end
         if (hit_en_two) begin
            enable.two <= pwdata[7:0] & irq_pkg::IMPL_TWO;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Priority registers

   // Default is high priority, so enabling priority mode with the group gate open changes nothing at first
   // Same lane and same reserved positions as the enable registers; the reserved
   // positions are forced low at reset too, so they read zero at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio.one <= irq_pkg::PRIO_RESET & irq_pkg::IMPL_ONE;
         prio.two <= irq_pkg::PRIO_RESET & irq_pkg::IMPL_TWO;
      end else if (wr && pstrb[0]) begin
         if (hit_prio_one) begin
            prio.one <= pwdata[7:0] & irq_pkg::IMPL_ONE;
         end
         if (hit_prio_two) begin
            prio.two <= pwdata[7:0] & irq_pkg::IMPL_TWO;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register

   // Scheme select and group gate; both off after reset
   // The group gate only matters in single-level mode. In priority mode the core's
   // own level gates take over, so the gate here is stored but does not route.
   // Bits above the two control bits are reserved and read back as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priority_scheme_on <= irq_pkg::CTRL_RESET;
         periph_group_gate  <= irq_pkg::CTRL_RESET;
      end else if (wr && pstrb[0] && hit_ctrl) begin
         priority_scheme_on <= pwdata[irq_pkg::CTRL_PRIO_BIT];
         periph_group_gate  <= pwdata[irq_pkg::CTRL_GROUP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event mask register

   // Per-byte strobes: byte 0 covers the first group, byte 1 the second
   // The mask only shapes irq; it never gates the request lines to the core.
   // Reserved positions stay zero, so they can never raise irq.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= '0;
      end else if (wr && hit_mask) begin
         if (pstrb[0]) begin
            mask.one <= pwdata[7:0] & irq_pkg::IMPL_ONE;
         end
         if (pstrb[1]) begin
            mask.two <= pwdata[15:8] & irq_pkg::IMPL_TWO;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-source gating

   // Flat 16-bit views of the carriers let one generate loop handle both
   // registers: bit 8*k+n of a view is bit n of register k.
   irq_pkg::src_bits_t flag_set;
   irq_pkg::src_bits_t status_clr;
   logic [15:0]        flag_v;
   logic [15:0]        en_v;
   logic [15:0]        prio_v;
   logic [15:0]        passed;
   logic [15:0]        high_v;
   logic [15:0]        low_v;
   logic [15:0]        impl_v;
   logic [15:0]        rise_v;
   logic [15:0]        flag_q_v;

   assign flag_v   = flags;
   assign en_v     = enable;
   assign prio_v   = prio;
   assign impl_v   = irq_pkg::IMPL_ALL;
   assign flag_q_v = flag_q;

   // One slice per source bit; reserved slices are forced off by impl_v
   genvar g;
   generate
      for (g = 0; g < irq_pkg::SRC_N; g++) begin : g_src
         assign passed[g] = flag_v[g] & en_v[g] & impl_v[g];
         assign high_v[g] = passed[g] & prio_v[g];
         assign low_v[g]  = passed[g] & ~prio_v[g];
         // Rising flag edge, seen whatever the enable says
         assign rise_v[g] = flag_v[g] & ~flag_q_v[g] & impl_v[g];
      end
   endgenerate

   // A flag that stays high raises status only once; software sees the same
   // source again only after its flag line has dropped and risen anew.
   assign flag_set = rise_v;

   // Write-one-to-clear, per byte lane; reserved ones are harmless, never set
   assign status_clr.one = (wr && hit_status && pstrb[0]) ? pwdata[7:0]  : 8'h00;
   assign status_clr.two = (wr && hit_status && pstrb[1]) ? pwdata[15:8] : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Request routing

   irq_pkg::irq_req_t next_req;

   // Without priority mode the priority bits are ignored and everything goes high,
   // gated by the group gate; with it the gate is left to the core's level gates.
   // The low line can only rise in priority mode, and then only for sources whose
   // priority bit is zero; reserved positions never reach either line.
   always_comb begin
      next_req = '0;
      if (priority_scheme_on) begin
         next_req.high = |high_v;
         next_req.low  = |low_v;
      end else begin
         next_req.high = periph_group_gate & (|passed);
         next_req.low  = 1'b0;
      end
   end

   // Registered so the core sees glitch-free levels; costs one cycle of latency
   // A change on the flag lines reaches core_req at the next rising edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_req <= '0;
      end else begin
         core_req <= next_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flag history for edge detection

   // Reset to the idle level of the flag lines, so no false edge follows reset;
   // a flag already high when reset ends is reported at the first edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= '0;
      end else begin
         flag_q <= flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky event status

   // Set wins over a clear in the same cycle, so no edge is lost to a racing write
   // Status bits are raised regardless of enables, so software can poll them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~status_clr) | flag_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event interrupt output

   // Next-state copy, so irq can be a flop without trailing status by a cycle
   irq_pkg::src_bits_t next_status;
   logic               next_irq;

   // Follows the status update so irq tracks status in the same cycle
   // A mask write reaches irq one cycle after the write completes
   assign next_status = (status & ~status_clr) | flag_set;
   assign next_irq    = |(next_status & mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

endmodule // peripheral_irq_enable_priority

`default_nettype wire

// File: verif/irq_prio_chk.sv
// Assertion checker for the peripheral interrupt enable and priority block.
`timescale 1ns/1ps
`default_nettype none

module irq_prio_chk (
   // Clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // APB slave side
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Flags, requests and event interrupt
   input wire irq_pkg::src_bits_t flags,
   input wire irq_pkg::irq_req_t  core_req,
   input wire logic               irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the written registers; strobes are ignored since the bench writes whole words
   irq_pkg::src_bits_t en, pr, mask, passed;
   logic [1:0]         ctrl;
   logic               done, rd, exp_high, exp_low;
   assign done = psel && penable && pready;
   assign rd   = done && !pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en   <= '0;
         pr   <= irq_pkg::IMPL_ALL;
         mask <= '0;
         ctrl <= 2'h0;
      end else if (done && pwrite) begin
         case (paddr)
            irq_pkg::OFF_EN_ONE:   en.one <= pwdata[7:0] & irq_pkg::IMPL_ONE;
            irq_pkg::OFF_EN_TWO:   en.two <= pwdata[7:0] & irq_pkg::IMPL_TWO;
            irq_pkg::OFF_PRIO_ONE: pr.one <= pwdata[7:0] & irq_pkg::IMPL_ONE;
            irq_pkg::OFF_PRIO_TWO: pr.two <= pwdata[7:0] & irq_pkg::IMPL_TWO;
            irq_pkg::OFF_CTRL:     ctrl <= pwdata[1:0];
            irq_pkg::OFF_MASK:     mask <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   // Expected routing; single-level mode sends everything to the high line
   assign passed   = flags & en;
   assign exp_high = ctrl[0] ? |(passed & pr) : (ctrl[1] & |passed);
   assign exp_low  = ctrl[0] & |(passed & ~pr);

   ////////////////////////////////////////////////////////////////////////////////
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   chk_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h01c
      |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   chk_reserved_one: assert property (rd && (paddr == 12'h000 || paddr == 12'h008)
      |-> prdata[31:7] == 25'h0) else $error("reserved bits of group one read nonzero");
   chk_reserved_two: assert property (rd && (paddr == 12'h004 || paddr == 12'h00c)
      |-> prdata[31:8] == 24'h0 && !prdata[0]) else $error("reserved bits of group two nonzero");
   chk_group_gate: assert property (ctrl == 2'h0 |=> core_req == 2'h0)
      else $error("request passed with group gate closed");
   chk_high_route: assert property (core_req.high == $past(exp_high))
      else $error("high request wrong");
   chk_low_route: assert property (core_req.low == $past(exp_low))
      else $error("low request wrong");
   chk_enable_block: assert property (passed == 16'h0 |=> core_req == 2'h0)
      else $error("request passed with enables off");
   chk_event_irq: assert property ((flags & ~$past(flags) & mask & irq_pkg::IMPL_ALL) != 16'h0
      |=> irq) else $error("unmasked event did not raise irq");

   cover property (done && pslverr);
   cover property (core_req.low);
   cover property ($rose(irq));
endmodule // irq_prio_chk

bind peripheral_irq_enable_priority irq_prio_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
   .core_req(core_req), .irq(irq));

`default_nettype wire

// File: verif/periph_side.sv
// Model of the peripheral flag sources and of the core sequencer taking requests.
`timescale 1ns/1ps
`default_nettype none

module periph_side (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Bench control and observation
   input  wire irq_pkg::src_bits_t want,
   output logic [7:0]              high_seen,
   // Block side
   output var irq_pkg::src_bits_t  flags,
   input  wire irq_pkg::irq_req_t  core_req
);
   logic prev_high;

   // Flags leave flops so they are synchronous to pclk, as the block expects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flags <= '0;
      else flags <= want;
   end
   // Sequencer counts each new high request offered to it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_high <= 1'b0;
         high_seen <= 8'h00;
      end else begin
         prev_high <= core_req.high;
         if (core_req.high && !prev_high) high_seen <= high_seen + 8'h01;
      end
   end
endmodule // periph_side

`default_nettype wire

// File: verif/peripheral_irq_enable_priority_test.sv
// Self-checking testbench for the peripheral interrupt enable and priority block.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_enable_priority_test;
   logic               pclk    = 1'b0;
   logic               presetn = 1'b0;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic [11:0]        paddr   = 12'h000;
   logic [31:0]        pwdata  = 32'h0;
   logic [31:0]        prdata;
   logic               pready, pslverr, irq;
   irq_pkg::src_bits_t want = '0;
   irq_pkg::src_bits_t flags;
   irq_pkg::irq_req_t  core_req;
   logic [7:0]         high_seen;
   int                 fail_count = 0;
   int                 checked = 0;

   always #25 pclk = ~pclk;

   peripheral_irq_enable_priority dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
      .core_req(core_req), .irq(irq));
   periph_side far (.pclk(pclk), .presetn(presetn), .want(want), .high_seen(high_seen),
      .flags(flags), .core_req(core_req));

   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high, for at most 16 cycles
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) fail_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask
   // Writes the group-one register at a and the group-two one just above it
   task automatic wr_pair(input logic [11:0] a, input logic [15:0] v);
      wr(a, {24'h0, v[7:0]});
      wr(a + 12'h004, {24'h0, v[15:8]});
   endtask
   // Requests are registered, so let the flag flop and the request flop both land
   task automatic settle;
      repeat (3) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_values;
      for (int i = 0; i < 7; i++) begin
         rd(12'(4 * i), (i == 2) ? 32'h7f : (i == 3) ? 32'hfe : 32'h0);
      end
      $display("test reset values done");
   endtask
   task automatic t_reg_access;
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 4; i++) begin
         wr(12'(4 * i), 32'hffff_ffff);
         rd(12'(4 * i), i[0] ? 32'hfe : 32'h7f);
         wr(12'(4 * i), 32'h0);
         rd(12'(4 * i), 32'h0);
      end
      apb(1'b0, 12'h020, 32'h0, r, e);
      check({r[31:1], e}, 32'h1);
      $display("test register access done");
   endtask
   task automatic t_routing;
      irq_pkg::src_bits_t b;
      logic               hit;
      wr_pair(irq_pkg::OFF_EN_ONE, 16'hffff);
      want <= 16'hffff;
      settle();
      check({30'h0, core_req}, 32'h0);
      wr(irq_pkg::OFF_CTRL, 32'h2);
      rd(irq_pkg::OFF_CTRL, 32'h2);
      settle();
      check({30'h0, core_req}, 32'h2);
      wr(irq_pkg::OFF_CTRL, 32'h1);
      for (int i = 0; i < 16; i++) begin
         b = 16'h0001 << i;
         hit = |(b & irq_pkg::IMPL_ALL);
         want <= b;
         wr_pair(irq_pkg::OFF_PRIO_ONE, b);
         settle();
         check({30'h0, core_req}, {30'h0, hit, 1'b0});
         wr_pair(irq_pkg::OFF_PRIO_ONE, 16'h0);
         settle();
         check({30'h0, core_req}, {31'h0, hit});
         wr_pair(irq_pkg::OFF_EN_ONE, ~b);
         settle();
         check({30'h0, core_req}, 32'h0);
         wr_pair(irq_pkg::OFF_EN_ONE, 16'hffff);
      end
      check({24'h0, high_seen}, 32'h0f);
      want <= 16'h0;
      wr(irq_pkg::OFF_CTRL, 32'h0);
      $display("test routing done");
   endtask
   task automatic t_events;
      wr_pair(irq_pkg::OFF_EN_ONE, 16'h0);
      wr(irq_pkg::OFF_STATUS, 32'hffff);
      wr(irq_pkg::OFF_MASK, 32'h0040);
      rd(irq_pkg::OFF_MASK, 32'h0040);
      rd(irq_pkg::OFF_STATUS, 32'h0);
      want <= 16'h8040;
      settle();
      rd(irq_pkg::OFF_STATUS, 32'h8040);
      rd(irq_pkg::OFF_FLAGS, 32'h8040);
      check({31'h0, irq}, 32'h1);
      wr(irq_pkg::OFF_MASK, 32'h0);
      settle();
      check({31'h0, irq}, 32'h0);
      wr(irq_pkg::OFF_MASK, 32'hffff);
      wr(irq_pkg::OFF_STATUS, 32'h0040);
      rd(irq_pkg::OFF_STATUS, 32'h8000);
      check({31'h0, irq}, 32'h1);
      wr(irq_pkg::OFF_STATUS, 32'h8000);
      settle();
      check({31'h0, irq}, 32'h0);
      want <= 16'h0;
      $display("test events done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and run control
   task automatic results;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // The whole run needs under a thousand cycles; this span leaves a wide margin
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_reg_access();
      t_routing();
      t_events();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      results();
   end
endmodule // peripheral_irq_enable_priority_test

`default_nettype wire
